//--- shared/i2cgp_params.svh
// register offsets, field positions and reset values of the i2c gating slice
`ifndef I2CGP_PARAMS_SVH
`define I2CGP_PARAMS_SVH

`define I2CGP_OFF_CLK_GATE      12'h00D8
`define I2CGP_OFF_SOFT_RST      12'h00DC
`define I2CGP_OFF_DSLP_REQ      12'h00E4
`define I2CGP_OFF_PERF_REQ      12'h00EC
`define I2CGP_OFF_WAKE_SRC      12'h0108

`define I2CGP_BIT_RUN_GATE      0
`define I2CGP_BIT_SLP_GATE      8
`define I2CGP_BIT_DSLP_GATE     16
`define I2CGP_BIT_SOFT_RST      0
`define I2CGP_BIT_ENABLED       1
`define I2CGP_BIT_REQ           0
`define I2CGP_BIT_WAKE_TIMER    0
`define I2CGP_BIT_WAKE_NETPROC  1

`define I2CGP_RST_VALUE         32'h0000_0000

`endif

//--- shared/i2cgp_pkg.sv
// types of the i2c gating slice
package i2cgp_pkg;

	typedef enum logic [1:0] {
		I2CGP_RUN,
		I2CGP_SLEEP,
		I2CGP_DEEP_SLEEP
	} i2cgp_mode_e;

	typedef struct packed {
		logic run_mode_clock_gate;
		logic sleep_mode_clock_gate;
		logic deep_sleep_clock_gate;
	} i2cgp_gate_s;

	typedef struct packed {
		logic netproc_wake_enable;
		logic wake_timer_enable;
	} i2cgp_wake_s;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} i2cgp_bus_s;

endpackage : i2cgp_pkg

//--- rtl/i2cgp_bit_reg.sv
// resettable control bit written from the register port
`timescale 1ns/1ps
module i2cgp_bit_reg (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// write side
	input  wire logic we,
	input  wire logic d,
	// stored value
	output logic      q
);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= 1'b0;
		end else if (we) begin
			q <= d;
		end
	end
endmodule : i2cgp_bit_reg

//--- rtl/i2cgp_top.sv
// i2c clock gating, soft reset and power request registers
`timescale 1ns/1ps
`include "i2cgp_params.svh"
module i2cgp_top
	import i2cgp_pkg::*;
(
	// clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        SYS_RST,
	// register port
	input  wire logic [11:0] ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA,
	// power mode of the application processor
	input  wire logic [1:0]  POWER_MODE,
	// wake sources
	input  wire logic        NETPROC_WAKE,
	input  wire logic        WAKE_TIMER_EXPIRED,
	// peripheral controls
	output logic             I2C_CLK_EN,
	output logic             I2C_SOFT_RESET,
	output logic             DEEP_SLEEP_ENTRY_REQ,
	output logic             HIGH_PERF_REQ,
	output logic             WAKE_TIMER_RUN,
	output logic             DEEP_SLEEP_WAKE
);

	////////////////////////////////////////////////////////////////////
	// address decode
	i2cgp_bus_s  bus;
	assign bus = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

	wire hit_gate = (bus.addr == `I2CGP_OFF_CLK_GATE);
	wire hit_rst  = (bus.addr == `I2CGP_OFF_SOFT_RST);
	wire hit_dslp = (bus.addr == `I2CGP_OFF_DSLP_REQ);
	wire hit_perf = (bus.addr == `I2CGP_OFF_PERF_REQ);
	wire hit_wake = (bus.addr == `I2CGP_OFF_WAKE_SRC);

	////////////////////////////////////////////////////////////////////
	// control bits
	localparam int NBITS = 8;
	logic [NBITS-1:0] we_v;
	logic [NBITS-1:0] d_v;
	logic [NBITS-1:0] q_v;

	// wake enables at bits 7 and 6
	assign we_v = {bus.wr & hit_wake, bus.wr & hit_wake,
		bus.wr & hit_perf, bus.wr & hit_dslp, bus.wr & hit_rst,
		bus.wr & hit_gate, bus.wr & hit_gate, bus.wr & hit_gate};
	assign d_v = {bus.wdata[`I2CGP_BIT_WAKE_NETPROC],
		bus.wdata[`I2CGP_BIT_WAKE_TIMER],
		bus.wdata[`I2CGP_BIT_REQ],
		bus.wdata[`I2CGP_BIT_REQ],
		bus.wdata[`I2CGP_BIT_SOFT_RST],
		bus.wdata[`I2CGP_BIT_DSLP_GATE],
		bus.wdata[`I2CGP_BIT_SLP_GATE],
		bus.wdata[`I2CGP_BIT_RUN_GATE]};

	// every control bit resets to zero
	genvar gi;
	generate
		for (gi = 0; gi < NBITS; gi++) begin : g_bit
			i2cgp_bit_reg u_bit (
				.clk (CLK_SYS),
				.rst (SYS_RST),
				.we  (we_v[gi]),
				.d   (d_v[gi]),
				.q   (q_v[gi])
			);
		end
	endgenerate

	i2cgp_gate_s gate;
	i2cgp_wake_s wake;
	assign gate = '{run_mode_clock_gate: q_v[0],
		sleep_mode_clock_gate: q_v[1], deep_sleep_clock_gate: q_v[2]};
	wire soft_rst_bit = q_v[3];
	wire dslp_req_bit = q_v[4];
	wire perf_req_bit = q_v[5];
	assign wake = '{wake_timer_enable: q_v[6], netproc_wake_enable: q_v[7]};

	////////////////////////////////////////////////////////////////////
	// clock gating per power mode
	i2cgp_mode_e mode;
	assign mode = i2cgp_mode_e'(POWER_MODE);
	logic clk_en_nxt;
	always_comb begin
		unique case (mode)
			I2CGP_RUN:        clk_en_nxt = gate.run_mode_clock_gate;
			I2CGP_SLEEP:      clk_en_nxt = gate.sleep_mode_clock_gate;
			I2CGP_DEEP_SLEEP: clk_en_nxt = gate.deep_sleep_clock_gate;
			default:          clk_en_nxt = 1'b0;
		endcase
	end

	// enabled when clocked and out of reset
	wire enabled_nxt = clk_en_nxt & ~soft_rst_bit;
	logic enabled_r;

	////////////////////////////////////////////////////////////////////
	// read mux
	wire [31:0] rd_gate = {15'h0000, gate.deep_sleep_clock_gate, 7'h00,
		gate.sleep_mode_clock_gate, 7'h00, gate.run_mode_clock_gate};
	wire [31:0] rd_rst  = {30'h0000_0000, enabled_r, soft_rst_bit};
	wire [31:0] rd_dslp = {31'h0000_0000, dslp_req_bit};
	wire [31:0] rd_perf = {31'h0000_0000, perf_req_bit};
	wire [31:0] rd_wake = {30'h0000_0000, wake.netproc_wake_enable,
		wake.wake_timer_enable};
	wire [31:0] rdata_nxt = !bus.rd ? `I2CGP_RST_VALUE :
		hit_gate ? rd_gate : hit_rst ? rd_rst : hit_dslp ? rd_dslp :
		hit_perf ? rd_perf : hit_wake ? rd_wake : `I2CGP_RST_VALUE;

	////////////////////////////////////////////////////////////////////
	// output flops
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			RDATA                <= `I2CGP_RST_VALUE;
			I2C_CLK_EN           <= 1'b0;
			I2C_SOFT_RESET       <= 1'b0;
			DEEP_SLEEP_ENTRY_REQ <= 1'b0;
			HIGH_PERF_REQ        <= 1'b0;
			WAKE_TIMER_RUN       <= 1'b0;
			DEEP_SLEEP_WAKE      <= 1'b0;
			enabled_r            <= 1'b0;
		end else begin
			RDATA                <= rdata_nxt;
			I2C_CLK_EN           <= clk_en_nxt;
			I2C_SOFT_RESET       <= soft_rst_bit;
			DEEP_SLEEP_ENTRY_REQ <= dslp_req_bit;
			HIGH_PERF_REQ        <= perf_req_bit;
			WAKE_TIMER_RUN       <= wake.wake_timer_enable;
			DEEP_SLEEP_WAKE      <= (mode == I2CGP_DEEP_SLEEP) &
				((wake.netproc_wake_enable & NETPROC_WAKE) |
				 (wake.wake_timer_enable & WAKE_TIMER_EXPIRED));
			enabled_r            <= enabled_nxt;
		end
	end

endmodule : i2cgp_top

//--- verification/i2cgp_monitor.sv
// port assertions of the i2c gating slice
`timescale 1ns/1ps
module i2cgp_monitor (
	// clock, reset and register port
	input wire logic	CLK_SYS,
	input wire logic	SYS_RST,
	input wire logic [11:0]	ADDR,
	input wire logic [31:0]	WDATA,
	input wire logic	WR,
	input wire logic	RD,
	input wire logic [31:0]	RDATA,
	// mode, wake and controls
	input wire logic [1:0]	POWER_MODE,
	input wire logic	NETPROC_WAKE,
	input wire logic	WAKE_TIMER_EXPIRED,
	input wire logic	I2C_CLK_EN,
	input wire logic	I2C_SOFT_RESET,
	input wire logic	DEEP_SLEEP_ENTRY_REQ,
	input wire logic	HIGH_PERF_REQ,
	input wire logic	DEEP_SLEEP_WAKE
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	run_gate_a: assert property (WR && ADDR == 12'h00D8 ##1
		POWER_MODE == 2'h0 |=> I2C_CLK_EN == $past(WDATA[0], 2))
		else $error("run gate");
	sleep_gate_a: assert property (WR && ADDR == 12'h00D8 ##1
		POWER_MODE == 2'h1 |=> I2C_CLK_EN == $past(WDATA[8], 2))
		else $error("sleep gate");
	deep_gate_a: assert property (WR && ADDR == 12'h00D8 ##1
		POWER_MODE == 2'h2 |=> I2C_CLK_EN == $past(WDATA[16], 2))
		else $error("deep gate");
	soft_reset_a: assert property (WR && ADDR == 12'h00DC |=> ##1
		I2C_SOFT_RESET == $past(WDATA[0], 2)) else $error("soft reset");
	deep_req_a: assert property (WR && ADDR == 12'h00E4 |=> ##1
		DEEP_SLEEP_ENTRY_REQ == $past(WDATA[0], 2)) else $error("deep req");
	perf_req_a: assert property (WR && ADDR == 12'h00EC |=> ##1
		HIGH_PERF_REQ == $past(WDATA[0], 2)) else $error("perf req");
	read_idle_a: assert property (!RD |=> RDATA == 32'h0000_0000)
		else $error("read idle");
	wake_cause_a: assert property (DEEP_SLEEP_WAKE |->
		$past(POWER_MODE) == 2'h2 &&
		$past(NETPROC_WAKE || WAKE_TIMER_EXPIRED))
		else $error("wake");
	cover property (I2C_CLK_EN);
	cover property (I2C_SOFT_RESET);
	cover property (DEEP_SLEEP_WAKE);
endmodule : i2cgp_monitor
bind i2cgp_top i2cgp_monitor u_mon (.CLK_SYS, .SYS_RST, .ADDR, .WDATA, .WR, .RD,
	.RDATA, .POWER_MODE, .NETPROC_WAKE, .WAKE_TIMER_EXPIRED, .I2C_CLK_EN,
	.I2C_SOFT_RESET, .DEEP_SLEEP_ENTRY_REQ, .HIGH_PERF_REQ, .DEEP_SLEEP_WAKE);

//--- verification/testbench.sv
// self-checking bench of the i2c gating slice
`timescale 1ns/1ps
module testbench;
	logic	clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, nw = 1'h0, te = 1'h0;
	logic	clk_en, srst, dreq, preq, trun, dwake;
	logic [1:0]	mode = 2'h0;
	logic [11:0]	addr = 12'h0000;
	logic [31:0]	wdata = 32'h0000_0000, rdata;
	int	bad_count = 0, n_tests = 0;
	always #50 clk = ~clk;
	i2cgp_top DUT (.CLK_SYS(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .POWER_MODE(mode), .NETPROC_WAKE(nw),
		.WAKE_TIMER_EXPIRED(te), .I2C_CLK_EN(clk_en), .I2C_SOFT_RESET(srst),
		.DEEP_SLEEP_ENTRY_REQ(dreq), .HIGH_PERF_REQ(preq),
		.WAKE_TIMER_RUN(trun), .DEEP_SLEEP_WAKE(dwake));
	task automatic chk(input string n, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wrt(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask : wrt
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 chk("rdata", e, rdata);
	endtask : rdc
	task automatic drv(input logic [1:0] m, input logic n, t);
		@(posedge clk);
		mode <= m;
		nw <= n;
		te <= t;
		repeat (2) @(posedge clk);
		#1;
	endtask : drv
	task automatic s_reset();
		logic [11:0] r [6] = '{12'h00D8, 12'h00DC, 12'h00E4,
			12'h00EC, 12'h0108, 12'h00E0};
		foreach (r[i]) rdc(r[i], 32'h0000_0000);
	endtask : s_reset
	task automatic s_gate();
		wrt(12'h00D8, 32'hFFFF_FFFF);
		rdc(12'h00D8, 32'h0001_0101);
		for (int m = 0; m < 3; m++) begin
			wrt(12'h00D8, 32'h0000_0001 << (8 * m));
			drv(2'(m), 1'h0, 1'h0);
			chk("clk on", 1'h1, clk_en);
			drv(2'((m + 1) % 3), 1'h0, 1'h0);
			chk("clk off", 1'h0, clk_en);
		end
		wrt(12'h00D8, 32'h0001_0101);
		drv(2'h3, 1'h0, 1'h0);
		chk("clk mode3", 1'h0, clk_en);
	endtask : s_gate
	task automatic s_srst();
		wrt(12'h00D8, 32'h0000_0001);
		wrt(12'h00DC, 32'hFFFF_FFFF);
		drv(2'h0, 1'h0, 1'h0);
		chk("srst", 1'h1, srst);
		rdc(12'h00DC, 32'h0000_0001);
		wrt(12'h00DC, 32'h0000_0000);
		drv(2'h0, 1'h0, 1'h0);
		chk("srst", 1'h0, srst);
		rdc(12'h00DC, 32'h0000_0002);
	endtask : s_srst
	task automatic s_req();
		wrt(12'h00E4, 32'hFFFF_FFFF);
		wrt(12'h00EC, 32'hFFFF_FFFF);
		wrt(12'h0108, 32'hFFFF_FFFD);
		drv(2'h0, 1'h0, 1'h0);
		chk("reqs", 3'h7, {dreq, preq, trun});
		rdc(12'h0108, 32'h0000_0001);
		rdc(12'h00EC, 32'h0000_0001);
		rdc(12'h00E4, 32'h0000_0001);
		wrt(12'h00E4, 32'h0000_0000);
		wrt(12'h00EC, 32'h0000_0000);
		drv(2'h0, 1'h0, 1'h0);
		chk("reqs off", 2'h0, {dreq, preq});
	endtask : s_req
	task automatic s_wake();
		wrt(12'h0108, 32'h0000_0002);
		drv(2'h2, 1'h1, 1'h0);
		chk("wake", 2'h1, {trun, dwake});
		drv(2'h2, 1'h0, 1'h1);
		chk("wake", 1'h0, dwake);
		drv(2'h0, 1'h1, 1'h0);
		chk("wake", 1'h0, dwake);
		wrt(12'h0108, 32'h0000_0001);
		drv(2'h2, 1'h0, 1'h1);
		chk("wake", 1'h1, dwake);
	endtask : s_wake
	task automatic complete_run();
		if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : complete_run
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		s_reset();
		s_gate();
		s_srst();
		s_req();
		s_wake();
		complete_run();
	end
	initial begin
		#200000;
		bad_count++;
		complete_run();
	end
endmodule : testbench
